/* File: hw/haptic_playback_power_control.sv */
// Playback sequencer, sample buffer, power enables and register slave of the haptic driver
//
// Functional notes
// RULE_01 - A buffer write wakes the device; playback starts after the start-up delay.
// RULE_02 - Playback stops itself when samples run out, no host action.
// RULE_03 - A nonzero DAC code at timeout ramps toward mid-scale at a safe rate.
// RULE_04 - Samples written during the ramp-down are discarded.
// RULE_05 - Standby bit high keeps lowest power and blocks every other mode.
// RULE_06 - Standby bit falling readies the device to accept samples.
// RULE_07 - Boost and amplifier enables driven internally, only while output is needed.
// RULE_08 - First sample reaches the DAC only after wake-up completes.
// RULE_09 - Force bit starts up at once and holds stages on until cleared.
// RULE_10 - Soft reset aborts playback, restores defaults and enters standby.
// RULE_11 - Two-bit gain selects 25, 50, 75 or 100 V full-scale peak.
// RULE_12 - Over-temperature disables both stages; operation resumes when it clears.
// RULE_13 - Brownout resets the device to its default state once it recovers.
// RULE_14 - Buffer empty waits out a timeout before going idle.
// RULE_15 - Samples are read out at 8 kHz and fed to the DAC.
// RULE_16 - Writes into a full buffer are refused; host resends from refused byte.
// RULE_17 - Timeout, ramp step and ramp interval are parameters with defaults.
//
// Decided for this implementation: the placing of the registers and register access over AXI4-Lite.
`timescale 1ns/1ps
module haptic_playback_power_control #(
    parameter int unsigned DEPTH = haptic_pkg::FIFO_DEPTH,
    parameter int unsigned STARTUP_CYCLES = haptic_pkg::STARTUP_CYC,
    parameter int unsigned SAMPLE_CYCLES = haptic_pkg::SAMPLE_CYC,
    // RULE_17 tunable timing
    parameter int unsigned IDLE_CYCLES = haptic_pkg::IDLE_CYC,
    parameter int unsigned RAMP_CYCLES = haptic_pkg::RAMP_CYC,
    parameter logic [7:0] RAMP_STEP = 8'(haptic_pkg::RAMP_STEP)
) (
    // Clocks and reset
    input wire logic clk,
    input wire logic reset_n,
    input wire logic linkClk,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Analog monitors (asynchronous pins)
    input wire logic overTemp,
    input wire logic brownout,
    // Output stage
    output logic boostEn,
    output logic ampEn,
    output logic [1:0] gainSel,
    output logic [7:0] dacCode
);
    import haptic_pkg::*;

    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    // Link side needs a few link cycles per code; faster updates would be lost
    if (DEPTH < 2 || STARTUP_CYCLES < 1 || IDLE_CYCLES < 1 || SAMPLE_CYCLES < 64
            || RAMP_CYCLES < 64 || RAMP_STEP == 8'h00) begin : g_bad_param
        $error("haptic_playback_power_control: unsupported parameter value");
    end

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic hotS1_q, hotS2_q, bodS1_q, bodS2_q;
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            hotS1_q <= 1'b0;
            hotS2_q <= 1'b0;
            bodS1_q <= 1'b0;
            bodS2_q <= 1'b0;
        end else begin
            hotS1_q <= overTemp;
            hotS2_q <= hotS1_q;
            bodS1_q <= brownout;
            bodS2_q <= bodS1_q;
        end
    end

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    logic awHeld_q, wHeld_q, bValid_q, rValid_q;
    logic [7:0] awAddr_q;
    logic [31:0] wData_q, rData_q;
    logic [3:0] wStrb_q;
    logic [1:0] bResp_q, rResp_q;
    logic wrFire, fifoWr, ctrlWr, pushOk, full, empty;
    logic softPulse_q, softClear;
    play_state_t state_q;

    assign s_axi_awready = !awHeld_q && !bValid_q;
    assign s_axi_wready = !wHeld_q && !bValid_q;
    assign s_axi_arready = !rValid_q;
    assign s_axi_bvalid = bValid_q;
    assign s_axi_bresp = bResp_q;
    assign s_axi_rvalid = rValid_q;
    assign s_axi_rresp = rResp_q;
    assign s_axi_rdata = rData_q;
    assign wrFire = awHeld_q && wHeld_q && !bValid_q;
    assign fifoWr = wrFire && awAddr_q == ADDR_FIFO && wStrb_q[0];
    assign ctrlWr = wrFire && awAddr_q == ADDR_CTRL && wStrb_q[0];

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            awHeld_q <= 1'b0;
            awAddr_q <= 8'h00;
            wHeld_q <= 1'b0;
            wData_q <= 32'h0;
            wStrb_q <= 4'h0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                awHeld_q <= 1'b1;
                awAddr_q <= {s_axi_awaddr[7:2], 2'b00};
            end else if (wrFire) begin
                awHeld_q <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                wHeld_q <= 1'b1;
                wData_q <= s_axi_wdata;
                wStrb_q <= s_axi_wstrb;
            end else if (wrFire) begin
                wHeld_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            bValid_q <= 1'b0;
            bResp_q <= RESP_OKAY;
        end else if (wrFire) begin
            bValid_q <= 1'b1;
            if (awAddr_q == ADDR_CTRL || awAddr_q == ADDR_STATUS) begin
                bResp_q <= RESP_OKAY;
            end else if (awAddr_q != ADDR_FIFO) begin
                bResp_q <= RESP_DECERR;
            // RULE_16 full refuse
            end else if (fifoWr && (state_q == ST_STANDBY || (full && state_q != ST_RAMP))) begin
                bResp_q <= RESP_SLVERR;
            end else begin
                bResp_q <= RESP_OKAY;
            end
        end else if (s_axi_bready) begin
            bValid_q <= 1'b0;
        end
    end

    // ****************************************
    // Control register
    // ****************************************
    logic standby_q, force_q;
    logic [1:0] gain_q;
    assign softClear = softPulse_q || bodS2_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            softPulse_q <= 1'b0;
        end else begin
            softPulse_q <= ctrlWr && wData_q[CTRL_SOFTRST_BIT];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            standby_q <= CTRL_STANDBY_RST;
            force_q <= CTRL_FORCE_RST;
            gain_q <= CTRL_GAIN_RST;
        // RULE_10 RULE_13 default restore
        end else if (softClear) begin
            standby_q <= CTRL_STANDBY_RST;
            force_q <= CTRL_FORCE_RST;
            gain_q <= CTRL_GAIN_RST;
        end else if (ctrlWr && !wData_q[CTRL_SOFTRST_BIT]) begin
            standby_q <= wData_q[CTRL_STANDBY_BIT];
            force_q <= wData_q[CTRL_FORCE_BIT];
            gain_q <= wData_q[CTRL_GAIN_LSB +: 2];
        end
    end

    // RULE_11 gain select: 00..11 give 25, 50, 75, 100 V peak
    assign gainSel = gain_q;

    // ****************************************
    // Sample buffer
    // ****************************************
    logic [7:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, rdPtr_q;
    logic [CW-1:0] level_q;
    logic pop;
    logic [31:0] cnt_q;
    logic [7:0] dac_q;

    assign full = level_q == CW'(DEPTH);
    assign empty = level_q == '0;
    // RULE_04 ramp discard
    assign pushOk = fifoWr && !full && state_q != ST_RAMP && state_q != ST_STANDBY;
    // RULE_15 sample tick
    assign pop = state_q == ST_PLAY && cnt_q == 32'h0 && !empty && !hotS2_q;

    always_ff @(posedge clk) begin
        if (pushOk) begin
            mem[wrPtr_q] <= wData_q[7:0];
        end
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            level_q <= '0;
        end else if (softClear) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            level_q <= '0;
        end else begin
            if (pushOk) begin
                wrPtr_q <= (wrPtr_q == AW'(DEPTH - 1)) ? '0 : wrPtr_q + 1'b1;
            end
            if (pop) begin
                rdPtr_q <= (rdPtr_q == AW'(DEPTH - 1)) ? '0 : rdPtr_q + 1'b1;
            end
            level_q <= level_q + CW'(pushOk) - CW'(pop);
        end
    end

    // ****************************************
    // Playback sequencer
    // ****************************************
    logic warm_q;
    play_state_t state_d;
    logic [31:0] cntLimit;

    always_comb begin
        case (state_q)
            ST_WAKE: cntLimit = STARTUP_CYCLES - 1;
            ST_PLAY: cntLimit = SAMPLE_CYCLES - 1;
            ST_TIMEOUT: cntLimit = IDLE_CYCLES - 1;
            ST_RAMP: cntLimit = RAMP_CYCLES - 1;
            default: cntLimit = 32'h0;
        endcase
    end

    always_comb begin
        state_d = state_q;
        case (state_q)
            // RULE_06 leave standby
            ST_STANDBY: if (!standby_q) state_d = ST_IDLE;
            ST_IDLE: begin
                // RULE_01 RULE_09 wake on sample or force
                // Warm forced stages wait here, so a new sample skips the wake delay
                if (force_q && warm_q) begin
                    if (!empty) state_d = ST_PLAY;
                end else if (!empty || force_q) begin
                    state_d = ST_WAKE;
                end
            end
            // RULE_08 wait for wake-up
            ST_WAKE: if (cnt_q == cntLimit) state_d = ST_PLAY;
            // RULE_02 underrun stop
            ST_PLAY: if (cnt_q == 32'h0 && empty) state_d = ST_TIMEOUT;
            ST_TIMEOUT: begin
                // RULE_14 RULE_03 timeout then ramp if needed
                if (!empty) state_d = ST_PLAY;
                else if (cnt_q == cntLimit) state_d = (dac_q == MID_SCALE) ? ST_IDLE : ST_RAMP;
            end
            ST_RAMP: if (dac_q == MID_SCALE) state_d = ST_IDLE;
            default: state_d = ST_STANDBY;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_q <= ST_STANDBY;
            cnt_q <= 32'h0;
        // RULE_05 RULE_10 standby wins
        end else if (softClear || standby_q) begin
            state_q <= ST_STANDBY;
            cnt_q <= 32'h0;
        // RULE_12 freeze while hot
        end else if (!hotS2_q) begin
            state_q <= state_d;
            if (state_d != state_q || cnt_q == cntLimit) begin
                cnt_q <= 32'h0;
            end else begin
                cnt_q <= cnt_q + 32'h1;
            end
        end
    end

    // Stages stay up between transfers only while forced and already started
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            warm_q <= 1'b0;
        end else if (!force_q || hotS2_q || softClear || standby_q) begin
            warm_q <= 1'b0;
        end else if (state_q == ST_WAKE && cnt_q == cntLimit) begin
            warm_q <= 1'b1;
        end
    end

    // RULE_07 RULE_09 RULE_12 stage enables
    assign boostEn = !standby_q && !hotS2_q && (force_q || (state_q != ST_STANDBY && state_q != ST_IDLE));
    assign ampEn = boostEn;

    // ****************************************
    // DAC code and ramp-down
    // ****************************************
    logic [7:0] dacMag;
    assign dacMag = dac_q[7] ? 8'(-dac_q) : dac_q;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dac_q <= MID_SCALE;
        end else if (softClear || standby_q) begin
            dac_q <= MID_SCALE;
        end else if (pop) begin
            dac_q <= mem[rdPtr_q];
        // RULE_03 stepped ramp
        end else if (state_q == ST_RAMP && cnt_q == 32'h0 && !hotS2_q) begin
            if (dacMag <= RAMP_STEP) dac_q <= MID_SCALE;
            else if (dac_q[7]) dac_q <= dac_q + RAMP_STEP;
            else dac_q <= dac_q - RAMP_STEP;
        end
    end

    // ****************************************
    // Register read
    // ****************************************
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rValid_q <= 1'b0;
            rData_q <= 32'h0;
            rResp_q <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            rValid_q <= 1'b1;
            rResp_q <= RESP_OKAY;
            rData_q <= 32'h0;
            case ({s_axi_araddr[7:2], 2'b00})
                ADDR_CTRL: begin
                    rData_q[CTRL_STANDBY_BIT] <= standby_q;
                    rData_q[CTRL_FORCE_BIT] <= force_q;
                    rData_q[CTRL_GAIN_LSB +: 2] <= gain_q;
                end
                ADDR_STATUS: begin
                    rData_q[STAT_FULL_BIT] <= full;
                    rData_q[STAT_EMPTY_BIT] <= empty;
                    rData_q[STAT_BOOST_BIT] <= boostEn;
                    rData_q[STAT_AMP_BIT] <= ampEn;
                    rData_q[STAT_HOT_BIT] <= hotS2_q;
                    rData_q[STAT_STATE_LSB +: 6] <= state_q;
                    rData_q[STAT_DAC_LSB +: 8] <= dac_q;
                    rData_q[STAT_LEVEL_LSB +: 8] <= 8'(level_q);
                end
                ADDR_FIFO: rData_q <= 32'h0;
                default: rResp_q <= RESP_DECERR;
            endcase
        end else if (s_axi_rready) begin
            rValid_q <= 1'b0;
        end
    end

    // ****************************************
    // Crossing to the output stage clock
    // ****************************************
    logic [7:0] dacHold_q, dacOut_q;
    logic reqTgl_q, tglS1_q, tglS2_q, tglS3_q;

    // Hold register changes with the toggle, so it is stable for one to two link cycles before the toggle is seen
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            dacHold_q <= MID_SCALE;
            reqTgl_q <= 1'b0;
        end else if (dac_q != dacHold_q) begin
            dacHold_q <= dac_q;
            reqTgl_q <= !reqTgl_q;
        end
    end

    always_ff @(posedge linkClk or negedge reset_n) begin
        if (!reset_n) begin
            tglS1_q <= 1'b0;
            tglS2_q <= 1'b0;
            tglS3_q <= 1'b0;
            dacOut_q <= MID_SCALE;
        end else begin
            tglS1_q <= reqTgl_q;
            tglS2_q <= tglS1_q;
            tglS3_q <= tglS2_q;
            if (tglS2_q != tglS3_q) dacOut_q <= dacHold_q;
        end
    end
    assign dacCode = dacOut_q;

    // ****************************************
    // Assertions
    // ****************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    standby_power_a: assert property (standby_q |-> (!boostEn && !ampEn) ##1 state_q == ST_STANDBY) // RULE_05
        else $error("stages on or playing during standby");
    idle_power_a: assert property (state_q == ST_IDLE && !force_q |-> !boostEn) // RULE_07
        else $error("boost enabled while idle");
    wake_length_a: assert property (state_q == ST_PLAY && $past(state_q) == ST_WAKE
            |-> $past(cnt_q) == STARTUP_CYCLES - 1) // RULE_08
        else $error("playback began before wake-up finished");
    force_hold_a: assert property (force_q && !standby_q && !hotS2_q |-> boostEn && ampEn) // RULE_09
        else $error("forced stages not enabled");
    thermal_off_a: assert property (hotS2_q |-> !boostEn && !ampEn) // RULE_12
        else $error("stages on while over temperature");
    ramp_discard_a: assert property (state_q == ST_RAMP && fifoWr && !pop
            |=> level_q == $past(level_q)) // RULE_04
        else $error("sample stored during ramp-down");
    full_refuse_a: assert property (fifoWr && full && state_q != ST_RAMP
            |=> s_axi_bvalid && s_axi_bresp == RESP_SLVERR) // RULE_16
        else $error("write into full buffer not refused");
    underrun_stop_a: assert property (state_q == ST_PLAY && cnt_q == 32'h0 && empty
            && !hotS2_q && !standby_q && !softClear |=> state_q == ST_TIMEOUT) // RULE_02
        else $error("underrun did not stop playback");
    ramp_toward_a: assert property (state_q == ST_RAMP && $past(state_q) == ST_RAMP
            |-> dacMag <= $past(dacMag)) // RULE_03
        else $error("ramp moved away from mid-scale");
    soft_reset_a: assert property (softClear |=> standby_q && level_q == '0
            && state_q == ST_STANDBY) // RULE_10
        else $error("soft reset did not restore defaults");

endmodule

/* File: shared/haptic_pkg.sv */
// Shared constants and types of the haptic playback power controller
package haptic_pkg;

    // ****************************************
    // Register map (byte addresses)
    // ****************************************
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_FIFO = 8'h08;

    // Control fields
    localparam int CTRL_STANDBY_BIT = 0;
    localparam int CTRL_FORCE_BIT = 1;
    localparam int CTRL_SOFTRST_BIT = 2;
    localparam int CTRL_GAIN_LSB = 3;
    localparam logic CTRL_STANDBY_RST = 1'b1;
    localparam logic CTRL_FORCE_RST = 1'b0;
    localparam logic [1:0] CTRL_GAIN_RST = 2'h0;

    // Status fields
    localparam int STAT_FULL_BIT = 0;
    localparam int STAT_EMPTY_BIT = 1;
    localparam int STAT_BOOST_BIT = 2;
    localparam int STAT_AMP_BIT = 3;
    localparam int STAT_HOT_BIT = 4;
    localparam int STAT_STATE_LSB = 8;
    localparam int STAT_DAC_LSB = 16;
    localparam int STAT_LEVEL_LSB = 24;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    // ****************************************
    // Timing
    // ****************************************
    localparam int CLK_PERIOD_NS = 4;
    localparam int STARTUP_NS = 2_000_000;
    localparam int SAMPLE_PERIOD_NS = 125_000;
    localparam int IDLE_TIMEOUT_NS = 10_000_000;
    localparam int RAMP_INTERVAL_NS = 125_000;
    localparam int STARTUP_CYC = (STARTUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SAMPLE_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    localparam int IDLE_CYC = (IDLE_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RAMP_CYC = RAMP_INTERVAL_NS / CLK_PERIOD_NS;
    localparam int RAMP_STEP = 1;
    localparam int FIFO_DEPTH = 100;
    localparam logic [7:0] MID_SCALE = 8'h00;

    // ****************************************
    // Playback states
    // ****************************************
    typedef enum logic [5:0] {
        ST_STANDBY = 6'h01,
        ST_IDLE = 6'h02,
        ST_WAKE = 6'h04,
        ST_PLAY = 6'h08,
        ST_TIMEOUT = 6'h10,
        ST_RAMP = 6'h20
    } play_state_t;

endpackage

/* File: tb/axi_host.sv */
// Host bus-master model driving the register port of the haptic controller
`timescale 1ns/1ps
module axi_host (
    // Clock
    input wire logic clk,
    // Write channels
    output logic [7:0] s_axi_awaddr,
    output logic s_axi_awvalid,
    input wire logic s_axi_awready,
    output logic [31:0] s_axi_wdata,
    output logic [3:0] s_axi_wstrb,
    output logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    output logic s_axi_bready,
    // Read channels
    output logic [7:0] s_axi_araddr,
    output logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0] s_axi_rresp,
    input wire logic s_axi_rvalid,
    output logic s_axi_rready
);
    initial {s_axi_awaddr, s_axi_awvalid, s_axi_wdata, s_axi_wstrb, s_axi_wvalid, s_axi_bready,
        s_axi_araddr, s_axi_arvalid, s_axi_rready} = '0;
    // Ready is sampled at the falling edge, where it is settled; released lines show the inverse
    task automatic write(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
        logic hA, hW, hB;
        r = 2'bxx;
        hB = 1'b0;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_wstrb <= 4'hf;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int n = 0; n < 1000 && !hB; n++) begin
            @(negedge clk);
            hA = s_axi_awvalid && s_axi_awready;
            hW = s_axi_wvalid && s_axi_wready;
            hB = s_axi_bvalid;
            if (hB) r = s_axi_bresp;
            @(posedge clk);
            if (hA) s_axi_awvalid <= 1'b0;
            if (hA) s_axi_awaddr <= ~a;
            if (hW) s_axi_wvalid <= 1'b0;
            if (hW) s_axi_wdata <= ~v;
            if (hB) s_axi_bready <= 1'b0;
        end
    endtask
    task automatic read(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
        logic hA, hR;
        {v, r} = 'x;
        hR = 1'b0;
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int n = 0; n < 1000 && !hR; n++) begin
            @(negedge clk);
            hA = s_axi_arvalid && s_axi_arready;
            hR = s_axi_rvalid;
            if (hR) {v, r} = {s_axi_rdata, s_axi_rresp};
            @(posedge clk);
            if (hA) s_axi_arvalid <= 1'b0;
            if (hA) s_axi_araddr <= ~a;
            if (hR) s_axi_rready <= 1'b0;
        end
    endtask
endmodule

/* File: tb/haptic_playback_power_control_test.sv */
// Self-checking bench of the haptic playback power controller
`timescale 1ns/1ps
module haptic_playback_power_control_test;
    import haptic_pkg::*;
    localparam int SAMPLE = 64;
    localparam int IDLE = 300;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic linkClk = 1'b0;
    logic overTemp = 1'b0;
    logic brownout = 1'b0;
    logic boostEn, ampEn;
    logic [1:0] gainSel, s_axi_bresp, s_axi_rresp, r;
    logic [7:0] dacCode, s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0] s_axi_wstrb;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    int errTotal = 0;
    int comparisons = 0;
    always #2 clk = ~clk;
    // Odd offset keeps link edges off the system clock edges
    initial begin
        #13;
        forever #40 linkClk = ~linkClk;
    end
    haptic_playback_power_control #(.DEPTH(4), .STARTUP_CYCLES(200), .SAMPLE_CYCLES(SAMPLE),
        .IDLE_CYCLES(IDLE), .RAMP_CYCLES(64)) dut (.clk(clk), .reset_n(reset_n),
        .linkClk(linkClk), .overTemp(overTemp), .brownout(brownout), .boostEn(boostEn),
        .ampEn(ampEn), .gainSel(gainSel), .dacCode(dacCode), .s_axi_awaddr(s_axi_awaddr),
        .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
        .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
        .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
        .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_rdata(s_axi_rdata),
        .s_axi_arready(s_axi_arready), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(s_axi_rready));
    axi_host host (.clk(clk), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
        .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));
    task automatic close_out();
        if (errTotal == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            errTotal++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic rd(input logic [7:0] a);
        host.read(a, d, r);
        if (r === 2'bxx) begin
            errTotal++;
            close_out();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] e);
        host.write(a, v, r);
        chk("bresp", 32'(e), 32'(r));
        if (r === 2'bxx) close_out();
    endtask
    task automatic until_state(input logic [5:0] s);
        for (int n = 0; n < 3000; n++) begin
            rd(ADDR_STATUS);
            if (d[STAT_STATE_LSB +: 6] === s) break;
        end
        chk("state", 32'(s), 32'(d[STAT_STATE_LSB +: 6]));
        if (d[STAT_STATE_LSB +: 6] !== s) close_out();
    endtask
    initial begin
        repeat (100000) @(posedge clk);
        errTotal++;
        close_out();
    end
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        rd(ADDR_CTRL);
        chk("ctrl", 32'h1, d);
        rd(8'h0c);
        chk("rresp", 32'(RESP_DECERR), 32'(r));
        wr(ADDR_FIFO, 32'h11, RESP_SLVERR);
        chk("boostEn", 32'h0, 32'(boostEn));
        wr(ADDR_CTRL, 32'h0, RESP_OKAY);
        for (int i = 1; i < 5; i++)
            wr(ADDR_FIFO, 32'(i * 16), RESP_OKAY);
        wr(ADDR_FIFO, 32'h50, RESP_SLVERR);
        repeat (140) @(posedge clk);
        rd(ADDR_STATUS);
        chk("status", 32'h0400040d, d);
        until_state(ST_PLAY);
        wr(ADDR_FIFO, 32'h50, RESP_OKAY);
        repeat (SAMPLE / 2) @(posedge clk);
        rd(ADDR_STATUS);
        chk("dac", 32'h10, 32'(d[STAT_DAC_LSB +: 8]));
        repeat (SAMPLE) @(posedge clk);
        rd(ADDR_STATUS);
        chk("dac", 32'h20, 32'(d[STAT_DAC_LSB +: 8]));
        until_state(ST_TIMEOUT);
        repeat (IDLE - 60) @(posedge clk);
        rd(ADDR_STATUS);
        chk("hold", 32'h5010, 32'(d[23:8]));
        chk("dacCode", 32'h50, 32'(dacCode));
        until_state(ST_RAMP);
        wr(ADDR_FIFO, 32'h33, RESP_OKAY);
        rd(ADDR_STATUS);
        chk("ramp", 32'h4f20, 32'(d[23:8]));
        chk("level", 32'h0, 32'(d[31:24]));
        until_state(ST_IDLE);
        repeat (100) @(posedge clk);
        chk("dacCode", 32'h0, 32'(dacCode));
        chk("boostEn", 32'h0, 32'(boostEn));
        for (int g = 0; g < 4; g++) begin
            wr(ADDR_CTRL, 32'(g << CTRL_GAIN_LSB), RESP_OKAY);
            chk("gainSel", 32'(g), 32'(gainSel));
        end
        wr(ADDR_CTRL, 32'h2, RESP_OKAY);
        repeat (4) @(posedge clk);
        chk("ampEn", 32'h1, 32'(ampEn));
        overTemp <= 1'b1;
        repeat (8) @(posedge clk);
        chk("boostEn", 32'h0, 32'(boostEn));
        overTemp <= 1'b0;
        repeat (8) @(posedge clk);
        chk("boostEn", 32'h1, 32'(boostEn));
        until_state(ST_IDLE);
        wr(ADDR_FIFO, 32'h05, RESP_OKAY);
        repeat (20) @(posedge clk);
        rd(ADDR_STATUS);
        chk("state", 32'(ST_PLAY), 32'(d[13:8]));
        wr(ADDR_CTRL, 32'h1c, RESP_OKAY);
        rd(ADDR_CTRL);
        chk("ctrl", 32'h1, d);
        rd(ADDR_STATUS);
        chk("status", 32'h00000102, d);
        wr(ADDR_CTRL, 32'h18, RESP_OKAY);
        brownout <= 1'b1;
        repeat (8) @(posedge clk);
        brownout <= 1'b0;
        repeat (8) @(posedge clk);
        rd(ADDR_CTRL);
        chk("ctrl", 32'h1, d);
        close_out();
    end
endmodule
